//--- hdl/sbi_pkg.sv
// shared bus interconnect package: widths, codes and lane helpers
package sbi_pkg;

	localparam int unsigned ADR_W   = 64;
	localparam int unsigned DAT_W   = 16;
	localparam int unsigned SEL_W   = 2;
	localparam int unsigned NUM_RSP = 2;

	// lane positions on the 16-bit port
	localparam int unsigned LANE_HI_LSB = 8;
	localparam int unsigned LANE_LO_LSB = 0;
	localparam int unsigned BYTE_W      = 8;

	// address bit that tells the two responders apart
	localparam int unsigned RSP_SEL_BIT = 8;
	// round robin pointer after reset, so the first initiator wins first
	localparam logic        LAST_RESET  = 1'b1;

	// port organisation codes
	typedef enum logic [1:0] {
		SBI_ORG_BYTE16 = 2'h0,
		SBI_ORG_WORD16 = 2'h1,
		SBI_ORG_BYTE8  = 2'h2
	} sbi_org_type;

	// arbiter states, one-hot
	typedef enum logic [2:0] {
		SBI_IDLE   = 3'b001,
		SBI_OWN_A  = 3'b010,
		SBI_OWN_B  = 3'b100
	} sbi_arb_type;

	localparam sbi_arb_type ARB_RESET = SBI_IDLE;

	// select lines for a transfer: byte16 uses adr bit 0, others select line 0 only
	function automatic logic [SEL_W-1:0] sbi_sel(input sbi_org_type org,
		input logic adr0,
		input logic big_endian);
		logic hi;
		hi = big_endian ? ~adr0 : adr0;
		unique case (org)
			SBI_ORG_BYTE16: sbi_sel = hi ? 2'h2 : 2'h1;
			default:        sbi_sel = 2'h1;
		endcase
	endfunction : sbi_sel

	// place a byte or word onto the lanes
	function automatic logic [DAT_W-1:0] sbi_place(input sbi_org_type org,
		input logic adr0,
		input logic big_endian,
		input logic [DAT_W-1:0] val);
		logic hi;
		hi = big_endian ? ~adr0 : adr0;
		unique case (org)
			SBI_ORG_BYTE16: sbi_place = hi ? {val[BYTE_W-1:0], 8'h00}
				: {8'h00, val[BYTE_W-1:0]};
			SBI_ORG_BYTE8:  sbi_place = {8'h00, val[BYTE_W-1:0]};
			default:        sbi_place = val;
		endcase
	endfunction : sbi_place

	// pick a byte or word back from the lanes
	function automatic logic [DAT_W-1:0] sbi_pick(input sbi_org_type org,
		input logic adr0,
		input logic big_endian,
		input logic [DAT_W-1:0] val);
		logic hi;
		hi = big_endian ? ~adr0 : adr0;
		unique case (org)
			SBI_ORG_BYTE16: sbi_pick = hi ? {8'h00, val[DAT_W-1:LANE_HI_LSB]}
				: {8'h00, val[BYTE_W-1:LANE_LO_LSB]};
			SBI_ORG_BYTE8:  sbi_pick = {8'h00, val[BYTE_W-1:0]};
			default:        sbi_pick = val;
		endcase
	endfunction : sbi_pick

endpackage : sbi_pkg

//--- hdl/sbi_if.sv
// shared bus interface joining the interconnect and the initiator/responder ends
`timescale 1ns/1ps
`default_nettype none
interface sbi_if;
	import sbi_pkg::*;

	logic [1:0]                   cyc;
	logic [1:0]                   stb;
	logic [1:0]                   we;
	logic [1:0][ADR_W-1:0]        adr;
	logic [1:0][SEL_W-1:0]        sel;
	logic [1:0][DAT_W-1:0]        dat_w;
	logic                         grant_first_initiator;
	logic                         grant_second_initiator;
	logic                         shared_cycle;
	logic                         shared_strobe;
	logic                         shared_we;
	logic [ADR_W-1:0]             shared_adr;
	logic [SEL_W-1:0]             shared_sel;
	logic [DAT_W-1:0]             shared_dat_w;
	logic [NUM_RSP-1:0]           rsp_ack;
	logic [NUM_RSP-1:0][DAT_W-1:0] rsp_dat;
	logic                         shared_acknowledge;
	logic [DAT_W-1:0]             shared_dat_r;

	modport fabric (
		input  cyc, stb, we, adr, sel, dat_w, rsp_ack, rsp_dat,
		output grant_first_initiator, grant_second_initiator, shared_cycle,
		shared_strobe, shared_we, shared_adr, shared_sel, shared_dat_w,
		shared_acknowledge, shared_dat_r
	);
	modport agents (
		output cyc, stb, we, adr, sel, dat_w, rsp_ack, rsp_dat,
		input  grant_first_initiator, grant_second_initiator, shared_cycle,
		shared_strobe, shared_we, shared_adr, shared_sel, shared_dat_w,
		shared_acknowledge, shared_dat_r
	);
endinterface : sbi_if
`default_nettype wire

//--- hdl/sbi_fabric.sv
// shared bus interconnect: arbiter, shared cycle/strobe mux, ack or, data mux
//
// Function
// - 16-bit byte port: adr 63..1, two lanes
// - 16-bit byte endian swaps lanes; words fixed
// - 8-bit port: lanes 7..0, ascending bytes
// - all logic on one rising clock edge
// - purely synchronous rtl, no timing tricks
// - initiator raises cycle to request arbiter
// - arbiter grants at most one of two initiators
// - grant steers cycle and strobe onto shared
// - shared acknowledge is or of responder acks
// - responder acks only when it is addressed
// - data joined through grant/decode multiplexers
// - matching single pair may wire directly
`timescale 1ns/1ps
`default_nettype none
module sbi_fabric (
	input  wire logic mclk,
	input  wire logic resetn,
	sbi_if.fabric     bus,
	output logic      busy,
	output logic      owner
);
	import sbi_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// arbiter

	sbi_arb_type arb_q;
	sbi_arb_type arb_d;
	logic        last_q;
	logic        last_d;

	always_comb begin
		arb_d  = arb_q;
		last_d = last_q;
		unique case (arb_q)
			SBI_IDLE: begin
				// round robin so a busy initiator cannot starve the other
				if (bus.cyc[0] && (!bus.cyc[1] || last_q)) begin
					arb_d  = SBI_OWN_A;
					last_d = 1'b0;
				end else if (bus.cyc[1]) begin
					arb_d  = SBI_OWN_B;
					last_d = 1'b1;
				end
			end
			SBI_OWN_A: begin
				if (!bus.cyc[0]) begin
					arb_d = SBI_IDLE;
				end
			end
			SBI_OWN_B: begin
				if (!bus.cyc[1]) begin
					arb_d = SBI_IDLE;
				end
			end
			default: arb_d = SBI_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			arb_q  <= ARB_RESET;
			last_q <= LAST_RESET;
		end else begin
			arb_q  <= arb_d;
			last_q <= last_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shared lines, grant from registered state only

	logic gnt_a;
	logic gnt_b;
	logic idx;

	always_comb begin
		gnt_a = (arb_q == SBI_OWN_A);
		gnt_b = (arb_q == SBI_OWN_B);
		idx   = gnt_b;
	end

	assign bus.grant_first_initiator  = gnt_a;
	assign bus.grant_second_initiator = gnt_b;
	// cycle and strobe pass only for the granted initiator
	assign bus.shared_cycle  = (gnt_a & bus.cyc[0]) | (gnt_b & bus.cyc[1]);
	assign bus.shared_strobe = (gnt_a & bus.stb[0]) | (gnt_b & bus.stb[1]);
	assign bus.shared_we     = bus.we[idx];
	assign bus.shared_adr    = bus.adr[idx];
	assign bus.shared_sel    = bus.sel[idx];
	assign bus.shared_dat_w  = bus.dat_w[idx];
	assign bus.shared_acknowledge = |bus.rsp_ack;

	// read data: responders drive zero when not acking, so an or is a mux
	always_comb begin
		bus.shared_dat_r = '0;
		for (int i = 0; i < NUM_RSP; i++) begin
			if (bus.rsp_ack[i]) begin
				bus.shared_dat_r = bus.shared_dat_r | bus.rsp_dat[i];
			end
		end
	end

	assign busy  = gnt_a | gnt_b;
	assign owner = gnt_b;

endmodule : sbi_fabric
`default_nettype wire

//--- hdl/sbi_agents.sv
// far end: two initiators and two registered responders on the shared bus
`timescale 1ns/1ps
`default_nettype none
module sbi_agents (
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	sbi_if.agents                          bus,
	input  wire logic [1:0]                req,
	input  wire logic [1:0]                req_we,
	input  wire logic [1:0][sbi_pkg::ADR_W-1:0] req_adr,
	input  wire logic [1:0][sbi_pkg::DAT_W-1:0] req_dat,
	input  wire sbi_pkg::sbi_org_type      org,
	input  wire logic                      big_endian,
	output logic [1:0]                     done,
	output logic [1:0][sbi_pkg::DAT_W-1:0] rd_dat
);
	import sbi_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// initiators: cycle raised on request, strobe once granted

	logic [1:0]                   cyc_q, cyc_d;
	logic [1:0]                   done_q, done_d;
	logic [1:0][DAT_W-1:0]        rd_q, rd_d;
	logic [1:0]                   gnt;

	assign gnt = {bus.grant_second_initiator, bus.grant_first_initiator};

	always_comb begin
		cyc_d  = cyc_q;
		done_d = '0;
		rd_d   = rd_q;
		for (int i = 0; i < 2; i++) begin
			if (!cyc_q[i] && req[i]) begin
				cyc_d[i] = 1'b1;
			end else if (cyc_q[i] && gnt[i] && bus.shared_acknowledge) begin
				cyc_d[i]  = 1'b0;
				done_d[i] = 1'b1;
				rd_d[i]   = sbi_pick(org, req_adr[i][0], big_endian, bus.shared_dat_r);
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cyc_q  <= '0;
			done_q <= '0;
			rd_q   <= '0;
		end else begin
			cyc_q  <= cyc_d;
			done_q <= done_d;
			rd_q   <= rd_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_init
			assign bus.cyc[g]   = cyc_q[g];
			assign bus.stb[g]   = cyc_q[g] & gnt[g];
			assign bus.we[g]    = req_we[g];
			assign bus.adr[g]   = req_adr[g];
			assign bus.sel[g]   = sbi_sel(org, req_adr[g][0], big_endian);
			assign bus.dat_w[g] = sbi_place(org, req_adr[g][0], big_endian,
				req_dat[g]);
		end
	endgenerate

	assign done   = done_q;
	assign rd_dat = rd_q;

	////////////////////////////////////////////////////////////////////////////
	// responders: decode address bit 8, ack one cycle after strobe

	logic [NUM_RSP-1:0]            ack_q, ack_d;
	logic [NUM_RSP-1:0][DAT_W-1:0] mem_q, mem_d;
	logic [NUM_RSP-1:0][DAT_W-1:0] rdat_q, rdat_d;

	always_comb begin
		ack_d  = '0;
		mem_d  = mem_q;
		rdat_d = '0;
		for (int r = 0; r < NUM_RSP; r++) begin
			// decode: only the addressed responder answers
			if (bus.shared_cycle && bus.shared_strobe && !ack_q[r]
				&& (bus.shared_adr[RSP_SEL_BIT] == r[0])) begin
				ack_d[r] = 1'b1;
				rdat_d[r] = mem_q[r];
				for (int b = 0; b < SEL_W; b++) begin
					// a word port has one select line that enables both lanes
					if (bus.shared_we && (bus.shared_sel[b]
						|| (org == SBI_ORG_WORD16 && bus.shared_sel[0]))) begin
						mem_d[r][b*BYTE_W +: BYTE_W] = bus.shared_dat_w[b*BYTE_W +: BYTE_W];
					end
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack_q  <= '0;
			mem_q  <= '0;
			rdat_q <= '0;
		end else begin
			ack_q  <= ack_d;
			mem_q  <= mem_d;
			rdat_q <= rdat_d;
		end
	end

	assign bus.rsp_ack = ack_q;
	assign bus.rsp_dat = rdat_q;

endmodule : sbi_agents
`default_nettype wire

//--- dv/sbi_assertions.sv
// checker on the shared bus between the fabric and the agents
`timescale 1ns/1ps
`default_nettype none
module sbi_assertions import sbi_pkg::*; (
	input wire logic               mclk,
	input wire logic               resetn,
	input wire logic [1:0]         cyc,
	input wire logic [1:0]         stb,
	input wire logic               grant_first_initiator,
	input wire logic               grant_second_initiator,
	input wire logic               shared_cycle,
	input wire logic               shared_strobe,
	input wire logic [ADR_W-1:0]   shared_adr,
	input wire logic [NUM_RSP-1:0] rsp_ack,
	input wire logic               shared_acknowledge
);
	wire logic g1 = grant_first_initiator;
	wire logic g2 = grant_second_initiator;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	grant_onehot_a: assert property (!(g1 && g2)) else $error("two grants");
	first_mux_a: assert property (g1 |->
		shared_cycle == cyc[0] && shared_strobe == stb[0]) else $error("first mux");
	second_mux_a: assert property (g2 |->
		shared_cycle == cyc[1] && shared_strobe == stb[1]) else $error("second mux");
	ack_or_a: assert property (shared_acknowledge == |rsp_ack) else $error("ack or");
	grant_take_a: assert property (!g1 && !g2 && |cyc |=> g1 || g2)
		else $error("no grant");
	grant_cause_a: assert property ($rose(g1) |-> $past(cyc[0])) else $error("stray grant");
	grant_hold_a: assert property (g1 && cyc[0] |=> g1) else $error("grant lost");
	grant_drop_a: assert property (g2 && !cyc[1] |=> !g2) else $error("grant stuck");
	ack_decode_a: assert property (rsp_ack[1] |->
		$past(shared_cycle && shared_strobe && shared_adr[RSP_SEL_BIT]))
		else $error("ack undecoded");
	cover property (g1 ##2 g2);
	cover property (&cyc && !g1 && !g2);
	cover property (rsp_ack[0]);
endmodule : sbi_assertions
`default_nettype wire

//--- dv/shared_bus_interconnect_tb.sv
// self-checking bench: two initiators and two responders on the shared bus
`timescale 1ns/1ps
`default_nettype none
module shared_bus_interconnect_tb;
	import sbi_pkg::*;
	logic                  mclk = 0;
	logic                  resetn = 0;
	logic [1:0]            req = 0;
	logic [1:0]            req_we = 0;
	logic [1:0]            done;
	logic [1:0][ADR_W-1:0] req_adr = '0;
	logic [1:0][DAT_W-1:0] req_dat = '0;
	logic [1:0][DAT_W-1:0] rd_dat;
	sbi_org_type           org = SBI_ORG_WORD16;
	logic                  big_endian = 0;
	logic                  busy;
	logic                  owner;
	logic [SEL_W-1:0]      sel_q;
	logic [DAT_W-1:0]      dat_q;
	logic [DAT_W-1:0]      d;
	logic                  hi;
	int                    fails = 0;
	int                    total_checks = 0;
	int                    cycles = 0;
	sbi_if sbi_bus ();
	sbi_fabric i_sbi_fabric (.mclk, .resetn, .bus(sbi_bus), .busy, .owner);
	sbi_agents i_sbi_agents (.mclk, .resetn, .bus(sbi_bus), .req, .req_we, .req_adr,
		.req_dat, .org, .big_endian, .done, .rd_dat);
	sbi_assertions i_sbi_assertions (.mclk, .resetn, .cyc(sbi_bus.cyc), .stb(sbi_bus.stb),
		.grant_first_initiator(sbi_bus.grant_first_initiator),
		.grant_second_initiator(sbi_bus.grant_second_initiator),
		.shared_cycle(sbi_bus.shared_cycle), .shared_strobe(sbi_bus.shared_strobe),
		.shared_adr(sbi_bus.shared_adr), .rsp_ack(sbi_bus.rsp_ack),
		.shared_acknowledge(sbi_bus.shared_acknowledge));
	always #20 mclk = ~mclk;
	// lanes caught mid-cycle while the strobe stands; the write is gone by done
	always @(negedge mclk) begin
		if (sbi_bus.shared_strobe && sbi_bus.shared_we) begin
			sel_q <= sbi_bus.shared_sel;
			dat_q <= sbi_bus.shared_dat_w;
		end
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [DAT_W-1:0] seen, logic [DAT_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic xfer(int i, logic we, logic [ADR_W-1:0] a, logic [DAT_W-1:0] v);
		req_we[i] = we;
		req_adr[i] = a;
		req_dat[i] = v;
		req[i] = 1;
		repeat (20) if (done[i] !== 1'b1) @(negedge mclk);
		check("done", 16'(done[i]), 16'h0001);
		req[i] = 0;
		@(negedge mclk);
	endtask : xfer
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge mclk);
		resetn = 1;
		@(negedge mclk);
		// both ask at once; the first owner after reset and the second owner after it are both pinned down
		req_adr[1] = ADR_W'(256);
		req = 2'b11;
		repeat (20) if (done === 2'b00) @(negedge mclk);
		check("first owner", 16'(done), 16'h0001);
		check("busy", 16'(busy), 16'h0001);
		check("owner", 16'(owner), 16'h0000);
		req[0] = 0;
		repeat (20) if (done[1] !== 1'b1) @(negedge mclk);
		check("second owner", 16'(done), 16'h0002);
		check("owner", 16'(owner), 16'h0001);
		req[1] = 0;
		@(negedge mclk);
		check("idle", 16'(busy), 16'h0000);
		for (int o = 0; o < 3; o++) for (int b = 0; b < 2; b++) for (int a = 0; a < 2; a++) begin
			org = sbi_org_type'(o);
			big_endian = b[0];
			hi = b[0] ^ a[0];
			d = 16'h5a30 + 16'(o * 4 + b * 2 + a);
			xfer(0, 1, ADR_W'(256 + a), d);
			check("sel", 16'(sel_q), (o == 0 && hi) ? 16'h0002 : 16'h0001);
			check("lanes", dat_q, o == 1 ? d : (o == 0 && hi) ? {d[7:0], 8'h00}
				: {8'h00, d[7:0]});
			xfer(1, 0, ADR_W'(256 + a), 16'h0000);
			check("read", rd_dat[1], o == 1 ? d : {8'h00, d[7:0]});
		end
		org = SBI_ORG_WORD16;
		xfer(1, 1, ADR_W'(0), 16'h1111);
		xfer(0, 1, ADR_W'(256), 16'h2222);
		xfer(0, 0, ADR_W'(0), 16'h0000);
		check("resp0", rd_dat[0], 16'h1111);
		xfer(1, 0, ADR_W'(256), 16'h0000);
		check("resp1", rd_dat[1], 16'h2222);
		end_of_test();
	end
endmodule : shared_bus_interconnect_tb
`default_nettype wire
